/* File: dv/bus_master.sv */
// Two-wire bus controller model that issues write transactions
module bus_master (
  // Clock
  input wire logic clock,
  // Bus lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic start();
    tick(1);
    sda_drv <= 1'b0;
    tick(8);
    scl <= 1'b0;
  endtask
  // Data moves only while SCL is low, well after the fall
  task automatic bit_out(input logic b);
    tick(5);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(8);
    scl <= 1'b0;
  endtask
  // MSB first, ninth period read back
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    tick(5);
    sda_drv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(6);
    ack = (sda_line === 1'b0);
    tick(2);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(5);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(8);
    sda_drv <= 1'b1;
    tick(8);
  endtask
endmodule

/* File: dv/tb_thermo_cmd_port.sv */
// Self-checking bench for the thermostat command port
module tb_thermo_cmd_port
  import thermo_cmd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, scl, sda_drv, sda_line, sda_out, sda_oe;
  logic [2:0] pins;
  logic one_shot, conv_done, converting, conversion_start, clock_en;
  logic [15:0] upper_threshold, lower_threshold, exp_up, exp_lo;
  int error_cnt, total_checks, cycles, starts;
  // Pull-up: low only when someone pulls
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  bus_master master_u (.clock(clock), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  thermo_cmd_port dut_u (.clock(clock), .resetn(resetn), .clock_en(clock_en), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .address_pin_high(pins[2]),
    .address_pin_mid(pins[1]), .address_pin_low(pins[0]), .single_conversion_select(one_shot),
    .conversion_done(conv_done), .converting(converting),
    .conversion_start(conversion_start), .upper_threshold(upper_threshold),
    .lower_threshold(lower_threshold));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (conversion_start === 1'b1) starts++;
    if (cycles == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  function automatic logic thr_cmd(input logic [7:0] c);
    return c == upper_threshold_access_command || c == lower_threshold_access_command;
  endfunction
  // One write transaction with all acknowledges checked
  task automatic xfer(input logic [7:0] ctrl, input logic [7:0] cmd, input int n,
                      input logic [15:0] d);
    logic ack, ok;
    ok = ctrl == {ctrl_family, pins, 1'b0};
    master_u.start();
    master_u.send_byte(ctrl, ack);
    compare(ack, ok, "control ack");
    if (ok) begin
      master_u.send_byte(cmd, ack);
      compare(ack, thr_cmd(cmd) || cmd == 8'h51 || cmd == 8'h22, "command ack");
      for (int i = 0; i < n; i++) begin
        master_u.send_byte(d[15 - 8 * i -: 8], ack);
        compare(ack, thr_cmd(cmd), "data ack");
      end
      if (n == 2 && cmd == upper_threshold_access_command) exp_up = d;
      if (n == 2 && cmd == lower_threshold_access_command) exp_lo = d;
    end
    master_u.stop();
    compare(upper_threshold, exp_up, "upper");
    compare(lower_threshold, exp_lo, "lower");
  endtask
  task automatic pulse_done();
    conv_done <= 1'b1;
    @(posedge clock);
    conv_done <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    logic [7:0] cmds [3];
    int s0;
    cmds = '{8'hA1, 8'hA2, 8'h3C};
    resetn = 1'b0;
    clock_en = 1'b1;
    pins = 3'h0;
    one_shot = 1'b1;
    conv_done = 1'b0;
    exp_up = threshold_reset;
    exp_lo = threshold_reset;
    s0 = $urandom(32'hfa62_3f0c);
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    compare(converting, 16'h0000, "reset converting");
    compare(sda_oe, 16'h0000, "reset answer");
    xfer(8'h90, 8'hA1, 2, 16'h2800);
    xfer(8'h90, 8'hA2, 2, 16'h0A00);
    xfer(8'h91, 8'hA1, 2, 16'h1234);
    for (int k = 0; k < 14; k++) begin
      pins <= 3'($urandom);
      @(posedge clock);
      xfer(($urandom % 4 == 0) ? 8'($urandom) : {ctrl_family, pins, 1'b0},
           cmds[$urandom % 3], $urandom % 3, 16'($urandom));
    end
    s0 = starts;
    xfer({ctrl_family, pins, 1'b0}, 8'h51, 1, 16'hFFFF);
    compare(16'(starts - s0), 16'h0001, "start pulse");
    compare(converting, 16'h0001, "running");
    // Bus idle here, so a frozen block must ignore the done pulse
    clock_en <= 1'b0;
    pulse_done();
    compare(converting, 16'h0001, "frozen");
    clock_en <= 1'b1;
    pulse_done();
    compare(converting, 16'h0000, "single done");
    one_shot <= 1'b0;
    xfer({ctrl_family, pins, 1'b0}, 8'h51, 0, 16'h0000);
    pulse_done();
    compare(converting, 16'h0001, "continuous");
    xfer({ctrl_family, pins, 1'b0}, 8'h22, 0, 16'h0000);
    compare(converting, 16'h0000, "stopped");
    finish_test();
  end
endmodule

/* File: logic/pin_sync.sv */
// Two-stage synchroniser for an asynchronous pin
module pin_sync
  import thermo_cmd_pkg::*;
(
  // Clock, reset and enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  // Pin and result
  input wire logic pin_in,
  output logic pin_out
);
  logic meta_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 1'b1;
      pin_out <= 1'b1;
    end else if (enable) begin
      meta_r <= pin_in;
      pin_out <= meta_r;
    end
  end
endmodule

/* File: logic/thermo_cmd_pkg.sv */
// Constants and types for the thermostat two-wire command port
package thermo_cmd_pkg;
  // ****************************************
  // Bus address and command codes
  // ****************************************
  localparam logic [3:0] ctrl_family = 4'h9;
  localparam logic [7:0] upper_threshold_access_command = 8'hA1;
  localparam logic [7:0] lower_threshold_access_command = 8'hA2;
  localparam logic [7:0] start_convert_command = 8'h51;
  localparam logic [7:0] stop_convert_command = 8'h22;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [15:0] threshold_reset = 16'h0000;
  localparam logic [2:0] bit_count_last = 3'h7;
  localparam logic [1:0] sync_stages = 2'h2;

  // Byte phase within a write transaction, Gray along the usual path
  typedef enum logic [2:0] {
    ph_idle = 3'b000,
    ph_ctrl = 3'b001,
    ph_cmd = 3'b011,
    ph_msb = 3'b010,
    ph_lsb = 3'b110,
    ph_done = 3'b111,
    ph_ignore = 3'b101
  } phase_t;
endpackage

/* File: logic/thermo_cmd_port.sv */
// Two-wire slave command port: threshold writes and conversion control
// Functional notes
// - The device acknowledges the control byte, the command byte and every written data byte; the code acks data bytes only as the two after A1h or A2h.
// - Command A1h selects the upper threshold, and its two data bytes load it.
// - Command A2h selects the lower threshold, and its two data bytes load it.
// - The first data byte is the whole-degree part in two's complement.
// - Command 51h starts conversion, carries no data, and is followed by STOP.
// - Start conversion runs once if single conversion is set, otherwise until stop conversion.
// - Bytes travel MSB first and each is answered in a ninth clock period.
// - Only a control byte of 1001, matching address pins, and direction bit is answered.
module thermo_cmd_port
  import thermo_cmd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic address_pin_high,
  input wire logic address_pin_mid,
  input wire logic address_pin_low,
  // Conversion mode and status
  input wire logic single_conversion_select,
  input wire logic conversion_done,
  output logic converting,
  output logic conversion_start,
  // Thresholds
  output logic [15:0] upper_threshold,
  output logic [15:0] lower_threshold
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_s, sda_s, scl_d_r, sda_d_r;

  pin_sync u_scl (
    .clock(clock), .resetn(resetn), .enable(clock_en), .pin_in(scl_in), .pin_out(scl_s)
  );
  pin_sync u_sda (
    .clock(clock), .resetn(resetn), .enable(clock_en), .pin_in(sda_in), .pin_out(sda_s)
  );
  // Straps are board pins, so they cross into this clock domain too
  logic apin_high_s, apin_mid_s, apin_low_s;
  pin_sync u_apin_high (
    .clock(clock), .resetn(resetn), .enable(clock_en), .pin_in(address_pin_high),
    .pin_out(apin_high_s)
  );
  pin_sync u_apin_mid (
    .clock(clock), .resetn(resetn), .enable(clock_en), .pin_in(address_pin_mid),
    .pin_out(apin_mid_s)
  );
  pin_sync u_apin_low (
    .clock(clock), .resetn(resetn), .enable(clock_en), .pin_in(address_pin_low),
    .pin_out(apin_low_s)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (clock_en) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_seen = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ****************************************
  // Bit and byte engine
  // ****************************************
  phase_t phase_r, phase_nxt;
  logic [7:0] shift_r;
  logic [2:0] bit_r;
  logic ack_slot_r;
  logic ack_drive_r;
  logic [7:0] cmd_r;
  logic [7:0] msb_r;
  logic conv_r;
  logic start_pulse_r;

  wire [2:0] own_address = {apin_high_s, apin_mid_s, apin_low_s};
  wire [7:0] byte_in = {shift_r[6:0], sda_s};
  // 8th bit sampled on this rising edge completes a byte
  wire byte_done = scl_rise & ~ack_slot_r & (bit_r == bit_count_last);
  wire addr_hit = (byte_in[7:4] == ctrl_family) && (byte_in[3:1] == own_address) && !byte_in[0];
  wire is_upper = (cmd_r == upper_threshold_access_command);
  wire is_lower = (cmd_r == lower_threshold_access_command);
  wire is_thresh_cmd = (byte_in == upper_threshold_access_command) ||
    (byte_in == lower_threshold_access_command);
  wire is_conv_cmd = (byte_in == start_convert_command) || (byte_in == stop_convert_command);
  wire take_ack = (phase_r == ph_ctrl) ? addr_hit :
    (phase_r == ph_cmd) ? (is_thresh_cmd | is_conv_cmd) :
    (phase_r == ph_msb) || (phase_r == ph_lsb);
  // both bytes in before the load
  wire load_thresh = byte_done && (phase_r == ph_lsb);

  always_comb begin
    phase_nxt = phase_r;
    if (byte_done) begin
      unique case (phase_r)
        ph_ctrl: phase_nxt = addr_hit ? ph_cmd : ph_ignore;
        ph_cmd: phase_nxt = is_thresh_cmd ? ph_msb : (is_conv_cmd ? ph_done : ph_ignore);
        ph_msb: phase_nxt = ph_lsb;
        ph_lsb: phase_nxt = ph_done;
        ph_idle, ph_done, ph_ignore: phase_nxt = ph_ignore;
      endcase
    end
    // START always restarts the control byte, STOP ends it
    if (start_seen) phase_nxt = ph_ctrl;
    else if (stop_seen) phase_nxt = ph_idle;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_r <= ph_idle;
      bit_r <= 3'h0;
      ack_slot_r <= 1'b0;
      shift_r <= 8'h00;
    end else if (clock_en) begin
      phase_r <= phase_nxt;
      if (start_seen || stop_seen) begin
        bit_r <= 3'h0;
        ack_slot_r <= 1'b0;
      end else if (scl_rise) begin
        // MSB first, ninth period is the answer slot
        if (ack_slot_r) begin
          ack_slot_r <= 1'b0;
        end else begin
          shift_r <= byte_in;
          bit_r <= bit_r + 3'h1;
          ack_slot_r <= (bit_r == bit_count_last);
        end
      end
    end
  end

  // ****************************************
  // Acknowledge driver
  // ****************************************
  logic ack_pend_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_pend_r <= 1'b0;
      ack_drive_r <= 1'b0;
    end else if (clock_en) begin
      if (start_seen || stop_seen) begin
        ack_pend_r <= 1'b0;
        ack_drive_r <= 1'b0;
      end else if (byte_done) begin
        ack_pend_r <= take_ack;
      end else if (scl_fall) begin
        // pull SDA low across the ninth period only
        ack_drive_r <= ack_pend_r & ack_slot_r;
        ack_pend_r <= 1'b0;
      end
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive_r;

  // ****************************************
  // Command and threshold registers
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_r <= 8'h00;
      msb_r <= 8'h00;
      upper_threshold <= threshold_reset;
      lower_threshold <= threshold_reset;
    end else if (clock_en && byte_done) begin
      if (phase_r == ph_cmd) cmd_r <= byte_in;
      // first byte is the signed whole-degree part
      if (phase_r == ph_msb) msb_r <= byte_in;
      if (load_thresh && is_upper) upper_threshold <= {msb_r, byte_in};
      if (load_thresh && is_lower) lower_threshold <= {msb_r, byte_in};
    end
  end

  // ****************************************
  // Conversion control
  // ****************************************
  wire conv_go = byte_done && (phase_r == ph_cmd) && (byte_in == start_convert_command);
  wire conv_halt = byte_done && (phase_r == ph_cmd) && (byte_in == stop_convert_command);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_r <= 1'b0;
      start_pulse_r <= 1'b0;
    end else if (clock_en) begin
      start_pulse_r <= conv_go;
      // one-shot ends on done, continuous runs until stop command
      if (conv_go) conv_r <= 1'b1;
      else if (conv_halt) conv_r <= 1'b0;
      else if (conversion_done && single_conversion_select) conv_r <= 1'b0;
    end
  end
  assign converting = conv_r;
  assign conversion_start = start_pulse_r;

  // ****************************************
  // Checks
  // ****************************************
  // Answer owed after a byte, and the fall that opens the answer slot
  sequence ack_due_s;
    clock_en && byte_done && take_ack && !start_seen && !stop_seen;
  endsequence
  sequence slot_open_s;
    clock_en && scl_fall && ack_pend_r && ack_slot_r && !start_seen && !stop_seen;
  endsequence
  chk_ack_armed: assert property (@(posedge clock) disable iff (!resetn)
    ack_due_s |=> ack_pend_r)
    else $error("acknowledge not armed");
  chk_ack_driven: assert property (@(posedge clock) disable iff (!resetn)
    slot_open_s |=> sda_oe)
    else $error("missing acknowledge");
  chk_addr_reject: assert property (@(posedge clock) disable iff (!resetn)
    clock_en && byte_done && phase_r == ph_ctrl && !addr_hit |=> !ack_pend_r)
    else $error("foreign address acknowledged");
  chk_upper_load: assert property (@(posedge clock) disable iff (!resetn)
    clock_en && load_thresh && is_upper |=> upper_threshold == {msb_r, $past(byte_in)})
    else $error("upper threshold not loaded");
  chk_lower_load: assert property (@(posedge clock) disable iff (!resetn)
    clock_en && load_thresh && is_lower |=> lower_threshold == {msb_r, $past(byte_in)})
    else $error("lower threshold not loaded");
  chk_whole_update: assert property (@(posedge clock) disable iff (!resetn)
    !(clock_en && load_thresh) |=> $stable(upper_threshold) && $stable(lower_threshold))
    else $error("threshold changed outside second byte");
  chk_msb_capture: assert property (@(posedge clock) disable iff (!resetn)
    clock_en && byte_done && phase_r == ph_msb |=> msb_r == $past(byte_in))
    else $error("first data byte lost");
  chk_conv_start: assert property (@(posedge clock) disable iff (!resetn)
    clock_en && conv_go |=> conversion_start && converting)
    else $error("conversion not started");
  chk_oneshot_end: assert property (@(posedge clock) disable iff (!resetn)
    clock_en && converting && conversion_done && single_conversion_select && !conv_go
    |=> !converting)
    else $error("one-shot did not end");
  chk_nine_slot: assert property (@(posedge clock) disable iff (!resetn)
    clock_en && byte_done && !start_seen && !stop_seen |=> ack_slot_r && bit_r == 3'h0)
    else $error("answer slot not after eighth bit");
endmodule
